// *** rtl/obtc_pkg.sv ***
package obtc_pkg;

   // Bus register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD_FREQ = 8'h04;
   localparam logic [7:0] OFS_IN_FUNC0 = 8'h08;
   localparam logic [7:0] OFS_RELAY_ONE = 8'h1C;
   localparam logic [7:0] OFS_RELAY_TWO = 8'h20;
   localparam logic [7:0] OFS_SS_EN = 8'h24;
   localparam logic [7:0] OFS_SS_START = 8'h28;
   localparam logic [7:0] OFS_GAIN = 8'h2C;
   localparam logic [7:0] OFS_TH_ACTION = 8'h30;
   localparam logic [7:0] OFS_COOLING = 8'h34;
   localparam logic [7:0] OFS_ONE_MIN = 8'h38;
   localparam logic [7:0] OFS_CONT = 8'h3C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_OUT_FREQ = 8'h44;
   localparam logic [7:0] OFS_DISP = 8'h48;
   localparam logic [7:0] OFS_HEAT = 8'h4C;
   localparam logic [7:0] OFS_FAULT_CNT = 8'h50;

   // Function codes and legal ranges
   localparam logic [7:0] FN_BLOCK = 8'h21;
   localparam logic [7:0] FN_IN_MIN = 8'h01;
   localparam logic [7:0] FN_IN_MAX = 8'h34;
   localparam logic [7:0] FN_RUNNING = 8'h0E;
   localparam logic [7:0] FN_RLY_MIN = 8'h01;
   localparam logic [7:0] FN_RLY_MAX = 8'h2C;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_COAST = 2'h1;
   localparam logic [1:0] ACT_DECEL = 2'h2;
   localparam logic COOL_SELF = 1'b0;
   localparam logic COOL_FORCED = 1'b1;
   localparam logic [7:0] ONE_MIN_LO = 8'h78;
   localparam logic [7:0] ONE_MIN_HI = 8'hC8;
   localparam logic [7:0] CONT_LO = 8'h32;
   localparam logic [7:0] CONT_HI = 8'h96;
   localparam logic [15:0] GAIN_LO = 16'h000A;
   localparam logic [15:0] GAIN_HI = 16'hEA60;
   localparam logic [31:0] GAIN_SCALE = 32'h000003E8;

   // Values after reset
   localparam logic [7:0] RST_IN_FUNC = 8'h01;
   localparam logic [7:0] RST_RELAY = 8'h0E;
   localparam logic [15:0] RST_GAIN = 16'h03E8;
   localparam logic [1:0] RST_TH_ACTION = ACT_NONE;
   localparam logic RST_COOLING = COOL_SELF;
   localparam logic [7:0] RST_ONE_MIN = 8'h96;
   localparam logic [7:0] RST_CONT = 8'h78;
   localparam logic [15:0] RST_SS_START = 16'h0000;

   // Timing of the thermal estimator
   localparam longint CLK_PERIOD_NS = 50;
   localparam longint TICK_TIME_MS = 1000;
   localparam longint TICK_CYC = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam longint TRIP_WINDOW_S = 60;
   localparam longint TRIP_TICKS = (TRIP_WINDOW_S * 1000) / TICK_TIME_MS;

   // Drive sequencing states
   typedef enum logic [2:0] {
      ST_STOP = 3'b000,
      ST_RUN = 3'b001,
      ST_BLOCK = 3'b010,
      ST_DECEL = 3'b011,
      ST_TRIP_DEC = 3'b100,
      ST_TRIPPED = 3'b101
   } obtc_state_t;

   // Thermal estimator settings
   typedef struct packed {
      logic [1:0] action;
      logic cooling;
      logic [7:0] one_min;
      logic [7:0] cont;
   } obtc_therm_cfg_t;

endpackage : obtc_pkg

// *** rtl/obtc_thermal.sv ***
`timescale 1ns/10ps
module obtc_thermal import obtc_pkg::*; #(
   parameter longint TICK_CYCLES = TICK_CYC,
   parameter longint TICKS_PER_MIN = TRIP_TICKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire obtc_therm_cfg_t cfg,
   input wire logic [7:0] cur_pct,
   input wire logic low_speed,
   input wire logic clear,
   output logic [31:0] heat_q,
   output logic trip_q
);

   logic [31:0] tick_cnt_q;
   logic tick;
   logic [7:0] cont_eff;
   logic [31:0] limit;
   logic [31:0] heat_d;

   // Shaft fan cools less at low speed, so derate
   assign cont_eff = (cfg.cooling == COOL_SELF && low_speed) ?
                     cfg.cont - (cfg.cont >> 2) : cfg.cont;
   assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
   assign limit = (cfg.one_min > cont_eff) ?
                  32'(cfg.one_min - cont_eff) * 32'(TICKS_PER_MIN) :
                  32'(TICKS_PER_MIN);
   // Heat integrates current above the continuous rating
   assign heat_d = (cur_pct > cont_eff) ? heat_q + 32'(cur_pct - cont_eff) :
                   (heat_q > 32'(cont_eff - cur_pct)) ?
                   heat_q - 32'(cont_eff - cur_pct) : 32'h00000000;

   // Tick timer
   always_ff @(posedge ref_clk) begin
      if (!rst_n || tick) tick_cnt_q <= 32'h00000000;
      else tick_cnt_q <= tick_cnt_q + 32'h00000001;
   end

   // Heat estimate and latched trip
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         heat_q <= 32'h00000000;
         trip_q <= 1'b0;
      end else begin
         if (tick) heat_q <= heat_d;
         // A new overheat wins over the clear from the stop state
         if (cfg.action != ACT_NONE && heat_q >= limit)
            trip_q <= 1'b1;
         else if (clear) trip_q <= 1'b0;
      end
   end

endmodule : obtc_thermal

// *** rtl/obtc_drive_ctrl.sv ***
// How it works
// - An input whose function select is 33 (range 1-52) requests blocking.
// - With run on, the output frequency ramps up to the command frequency.
// - On release a speed search starts from the stored search setting.
// - After release the drive ramps to the command with no reset needed.
// - A relay set to code 14 (range 1-44) stays on while blocked.
// - While blocked the display shows the output-block indication.
// - Release clears the block by itself and logs no fault.
// - Displayed speed is measured rpm times the gain, default 100.0 %.
// - Motor heat is estimated from output current without a sensor.
// - Thermal action select takes 0 to 2, default 0 meaning none.
// - One-minute rating is 120 to 200 percent, default 150.
// - Continuous rating is 50 to 150 percent, default 120.
// - Cooling type exists and defaults to self-cooled.
// - Thermal trip action 1 coasts, action 2 decelerates to stop.
// - Cooling 0 is shaft fan weak at low speed, 1 is forced cooling.
`timescale 1ns/10ps
module obtc_drive_ctrl import obtc_pkg::*; #(
   parameter int unsigned N_IN = 5,
   parameter logic [15:0] LOW_SPEED = 16'h0100,
   parameter longint TICK_CYCLES = TICK_CYC,
   parameter longint TICKS_PER_MIN = TRIP_TICKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [N_IN-1:0] term_in,
   input wire logic [15:0] meas_rpm,
   input wire logic [7:0] out_cur_pct,
   output logic stage_en_q,
   output logic [15:0] out_freq_q,
   output logic [1:0] relay_q,
   output logic disp_block_q,
   output logic [15:0] disp_speed_q
);

   // Clamp step toward a target frequency
   function automatic logic [15:0] step_to(input logic [15:0] cur,
                                           input logic [15:0] tgt);
      if (cur < tgt) step_to = cur + 16'h0001;
      else if (cur > tgt) step_to = cur - 16'h0001;
      else step_to = cur;
   endfunction : step_to

   // Range check of a byte setting
   function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      in_rng = (v >= lo) && (v <= hi);
   endfunction : in_rng

   obtc_state_t state_q, state_d;
   logic run_q;
   logic ss_en_q;
   logic [15:0] cmd_freq_q, ss_start_q, gain_q;
   logic [7:0] in_func_q [N_IN];
   logic [7:0] relay_fn_q [2];
   obtc_therm_cfg_t th_q;
   logic [15:0] fault_cnt_q;
   logic [N_IN-1:0] s1_q, s2_q, s3_q, filt_q;
   logic [N_IN-1:0] fn_hit;
   logic blk_req;
   logic [31:0] heat;
   logic trip;
   logic [15:0] freq_d, ss_target;
   logic stage_d, running;
   logic [31:0] disp_prod, disp_div;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic addr_ok;
   logic [7:0] a_ofs;
   logic [31:0] rd_mux;
   logic [7:0] wb;
   logic [2:0] in_idx;

   // Pin inputs pass three flops; a change counts when stages 2 and 3 agree
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end else begin
         s1_q <= term_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < N_IN; i++)
            if (s2_q[i] == s3_q[i]) filt_q[i] <= s3_q[i];
      end
   end

   // Block request is a level from any input set to the block function
   generate
      for (genvar g = 0; g < N_IN; g++) begin : g_fn
         assign fn_hit[g] = filt_q[g] && (in_func_q[g] == FN_BLOCK);
      end
   endgenerate
   assign blk_req = |fn_hit;

   // Thermal estimator
   obtc_thermal #(
      .TICK_CYCLES(TICK_CYCLES),
      .TICKS_PER_MIN(TICKS_PER_MIN)
   ) u_thermal (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cfg(th_q),
      .cur_pct(out_cur_pct),
      .low_speed(out_freq_q < LOW_SPEED),
      .clear(state_q == ST_STOP),
      .heat_q(heat),
      .trip_q(trip)
   );

   // Search resumes from the stored setting, never above the command
   assign ss_target = (ss_start_q < cmd_freq_q) ? ss_start_q : cmd_freq_q;

   // Sequencer next state and frequency
   always_comb begin
      state_d = state_q;
      freq_d = out_freq_q;
      stage_d = stage_en_q;
      unique case (state_q)
         ST_STOP: begin
            freq_d = 16'h0000;
            stage_d = 1'b0;
            if (run_q && blk_req) state_d = ST_BLOCK;
            else if (run_q) begin
               state_d = ST_RUN;
               stage_d = 1'b1;
               if (ss_en_q) freq_d = ss_target;
            end
         end
         ST_RUN, ST_DECEL: begin
            if (trip && th_q.action == ACT_COAST) begin
               state_d = ST_TRIPPED;
               freq_d = 16'h0000;
               stage_d = 1'b0;
            end else if (trip && th_q.action == ACT_DECEL) begin
               state_d = ST_TRIP_DEC;
            end else if (blk_req) begin
               state_d = ST_BLOCK;
               freq_d = 16'h0000;
               stage_d = 1'b0;
            end else if (run_q) begin
               state_d = ST_RUN;
               freq_d = step_to(out_freq_q, cmd_freq_q);
            end else if (out_freq_q == 16'h0000) begin
               state_d = ST_STOP;
               stage_d = 1'b0;
            end else begin
               state_d = ST_DECEL;
               freq_d = step_to(out_freq_q, 16'h0000);
            end
         end
         ST_BLOCK: begin
            freq_d = 16'h0000;
            stage_d = 1'b0;
            if (!run_q) state_d = ST_STOP;
            else if (!blk_req) begin
               state_d = ST_RUN;
               freq_d = ss_target;
               stage_d = 1'b1;
            end
         end
         ST_TRIP_DEC: begin
            freq_d = step_to(out_freq_q, 16'h0000);
            if (out_freq_q == 16'h0000) begin
               state_d = ST_TRIPPED;
               stage_d = 1'b0;
            end
         end
         ST_TRIPPED: begin
            freq_d = 16'h0000;
            stage_d = 1'b0;
            if (!run_q) state_d = ST_STOP;
         end
         default: begin
            state_d = ST_STOP;
            freq_d = 16'h0000;
            stage_d = 1'b0;
         end
      endcase
   end

   // Running counts blocked time as operating
   assign running = (state_q == ST_RUN) || (state_q == ST_BLOCK) ||
                    (state_q == ST_DECEL) || (state_q == ST_TRIP_DEC);
   // Speed display scaling in tenths of a percent
   assign disp_prod = 32'(meas_rpm) * 32'(gain_q);
   assign disp_div = disp_prod / GAIN_SCALE;

   // Sequencer and output registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= ST_STOP;
         out_freq_q <= 16'h0000;
         stage_en_q <= 1'b0;
         relay_q <= 2'b00;
         disp_block_q <= 1'b0;
         disp_speed_q <= 16'h0000;
         fault_cnt_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         out_freq_q <= freq_d;
         stage_en_q <= stage_d;
         for (int r = 0; r < 2; r++)
            relay_q[r] <= running && (relay_fn_q[r] == FN_RUNNING);
         disp_block_q <= (state_d == ST_BLOCK);
         disp_speed_q <= (disp_div > 32'h0000FFFF) ? 16'hFFFF :
                         disp_div[15:0];
         if (trip && (state_q == ST_RUN || state_q == ST_DECEL) &&
             th_q.action != ACT_NONE)
            fault_cnt_q <= fault_cnt_q + 16'h0001;
      end
   end

   // Bus address decode
   assign a_ofs = haddr[7:0];
   assign addr_ok = hsel && htrans[1] && hready;
   assign wb = hwdata[7:0];
   assign in_idx = 3'((wr_addr_q - OFS_IN_FUNC0) >> 2);

   // Read data of the addressed register
   always_comb begin
      rd_mux = 32'h00000000;
      for (int i = 0; i < N_IN; i++)
         if (a_ofs == OFS_IN_FUNC0 + 8'(4 * i)) rd_mux = 32'(in_func_q[i]);
      unique case (a_ofs)
         OFS_CTRL: rd_mux = 32'(run_q);
         OFS_CMD_FREQ: rd_mux = 32'(cmd_freq_q);
         OFS_RELAY_ONE: rd_mux = 32'(relay_fn_q[0]);
         OFS_RELAY_TWO: rd_mux = 32'(relay_fn_q[1]);
         OFS_SS_EN: rd_mux = 32'(ss_en_q);
         OFS_SS_START: rd_mux = 32'(ss_start_q);
         OFS_GAIN: rd_mux = 32'(gain_q);
         OFS_TH_ACTION: rd_mux = 32'(th_q.action);
         OFS_COOLING: rd_mux = 32'(th_q.cooling);
         OFS_ONE_MIN: rd_mux = 32'(th_q.one_min);
         OFS_CONT: rd_mux = 32'(th_q.cont);
         OFS_STATUS: rd_mux = {24'h000000, trip, stage_en_q,
                               state_q == ST_BLOCK, blk_req, 1'b0, state_q};
         OFS_OUT_FREQ: rd_mux = 32'(out_freq_q);
         OFS_DISP: rd_mux = 32'(disp_speed_q);
         OFS_HEAT: rd_mux = heat;
         OFS_FAULT_CNT: rd_mux = 32'(fault_cnt_q);
         default: ;
      endcase
   end

   // Bus slave: zero wait, read data registered into the data phase
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) wr_addr_q <= a_ofs;
         if (addr_ok && !hwrite) hrdata <= rd_mux;
      end
   end

   // Settings; out-of-range writes leave the old value
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         cmd_freq_q <= 16'h0000;
         ss_en_q <= 1'b0;
         ss_start_q <= RST_SS_START;
         gain_q <= RST_GAIN;
         for (int i = 0; i < N_IN; i++) in_func_q[i] <= RST_IN_FUNC;
         relay_fn_q[0] <= RST_RELAY;
         relay_fn_q[1] <= RST_RELAY;
         th_q <= {RST_TH_ACTION, RST_COOLING, RST_ONE_MIN, RST_CONT};
      end else if (wr_pend_q) begin
         unique case (wr_addr_q)
            OFS_CTRL: run_q <= hwdata[0];
            OFS_CMD_FREQ: cmd_freq_q <= hwdata[15:0];
            OFS_RELAY_ONE:
               if (in_rng(wb, FN_RLY_MIN, FN_RLY_MAX)) relay_fn_q[0] <= wb;
            OFS_RELAY_TWO:
               if (in_rng(wb, FN_RLY_MIN, FN_RLY_MAX)) relay_fn_q[1] <= wb;
            OFS_SS_EN: ss_en_q <= hwdata[0];
            OFS_SS_START: ss_start_q <= hwdata[15:0];
            OFS_GAIN:
               if (hwdata[15:0] >= GAIN_LO && hwdata[15:0] <= GAIN_HI)
                  gain_q <= hwdata[15:0];
            OFS_TH_ACTION: if (wb <= 8'h02) th_q.action <= wb[1:0];
            OFS_COOLING: th_q.cooling <= hwdata[0];
            OFS_ONE_MIN:
               if (in_rng(wb, ONE_MIN_LO, ONE_MIN_HI))
                  th_q.one_min <= wb;
            OFS_CONT:
               if (in_rng(wb, CONT_LO, CONT_HI)) th_q.cont <= wb;
            default:
               if (wr_addr_q >= OFS_IN_FUNC0 && wr_addr_q < OFS_RELAY_ONE &&
                   in_idx < 3'(N_IN) && in_rng(wb, FN_IN_MIN, FN_IN_MAX))
                  in_func_q[in_idx] <= wb;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_blocked;
      state_q == ST_BLOCK && run_q;
   endsequence
   sequence seq_release;
      !blk_req;
   endsequence

   chk_block_stage: assert property (
      (state_q == ST_RUN && blk_req && !trip) |=> !stage_en_q &&
      state_q == ST_BLOCK && out_freq_q == 16'h0000)
      else $error("block did not stop the stage");
   chk_release_search: assert property (
      (seq_blocked ##0 seq_release) |=> state_q == ST_RUN && stage_en_q &&
      out_freq_q == $past(ss_target))
      else $error("release did not start from search value");
   chk_resume_ramp: assert property (
      (seq_blocked ##0 seq_release ##1 (run_q && !blk_req && !trip &&
      out_freq_q < cmd_freq_q)) |=> out_freq_q == $past(out_freq_q) + 16'h0001)
      else $error("no ramp after release");
   chk_ramp_up: assert property (
      (state_q == ST_RUN && run_q && !blk_req && !trip &&
      out_freq_q < cmd_freq_q) |=> out_freq_q == $past(out_freq_q) + 16'h0001)
      else $error("ramp step wrong");
   chk_relay_run: assert property (
      (state_q == ST_BLOCK && relay_fn_q[0] == FN_RUNNING) |=> relay_q[0])
      else $error("relay dropped while blocked");
   chk_block_disp: assert property (
      (state_q == ST_BLOCK) |-> disp_block_q)
      else $error("indication missing while blocked");
   chk_no_fault_log: assert property (
      (state_q == ST_BLOCK) |=> $stable(fault_cnt_q))
      else $error("block was logged as a fault");
   chk_trip_coast: assert property (
      (state_q == ST_RUN && trip && th_q.action == ACT_COAST) |=>
      state_q == ST_TRIPPED ##0 !stage_en_q [*2])
      else $error("coast trip did not cut the stage");
   chk_cfg_range: assert property (
      th_q.action <= ACT_DECEL && th_q.one_min >= ONE_MIN_LO &&
      th_q.one_min <= ONE_MIN_HI && th_q.cont >= CONT_LO &&
      th_q.cont <= CONT_HI)
      else $error("thermal setting out of range");

endmodule : obtc_drive_ctrl

// *** tb/obtc_motor_model.sv ***
`timescale 1ns/10ps
module obtc_motor_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic stage_en_q,
   input wire logic [15:0] out_freq_q,
   input wire logic block_cmd,
   input wire logic aux_cmd,
   input wire logic [7:0] load_pct,
   output logic [4:0] term_in,
   output logic [15:0] meas_rpm,
   output logic [7:0] out_cur_pct
);
   // Terminal levels held for as long as the controller wants them
   always_ff @(posedge ref_clk) begin
      term_in <= {2'b00, block_cmd, 1'b0, aux_cmd};
   end

   // Shaft follows the stage, coasts down when the stage is off
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meas_rpm <= 16'h0000;
      end else if (stage_en_q) begin
         meas_rpm <= out_freq_q;
      end else if (meas_rpm != 16'h0000) begin
         meas_rpm <= meas_rpm - 16'h0001;
      end
   end

   // Current drawn only while the stage feeds the motor
   always_ff @(posedge ref_clk) begin
      out_cur_pct <= stage_en_q ? load_pct : 8'h00;
   end
endmodule : obtc_motor_model

// *** tb/obtc_drive_ctrl_bench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT_UNTIL(c, lim) begin n = 0; \
 while (!(c) && n < lim) begin @(posedge ref_clk); #1; n++; end \
 if (!(c)) begin num_errors++; $display("Wait ran out t=%0t", $time); \
 results(); end end
module obtc_drive_ctrl_bench;
   import obtc_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } obtc_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, stage_en_q, disp_block_q;
   logic [31:0] hrdata, rd;
   logic [4:0] term_in;
   logic [15:0] meas_rpm, out_freq_q, disp_speed_q;
   logic [7:0] out_cur_pct;
   logic [7:0] load_pct = 8'h10;
   logic [1:0] relay_q;
   logic block_cmd = 1'b0;
   logic aux_cmd = 1'b0;
   int num_errors = 0;
   int checks_done = 0;
   int n;
   obtc_row_t rows [29];

   // Clock of 50 ns
   always #25 ref_clk = ~ref_clk;

   obtc_drive_ctrl #(.TICK_CYCLES(4), .TICKS_PER_MIN(2)) i_obtc_drive_ctrl (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .term_in(term_in), .meas_rpm(meas_rpm),
      .out_cur_pct(out_cur_pct), .stage_en_q(stage_en_q),
      .out_freq_q(out_freq_q), .relay_q(relay_q),
      .disp_block_q(disp_block_q), .disp_speed_q(disp_speed_q));

   obtc_motor_model i_obtc_motor_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .stage_en_q(stage_en_q),
      .out_freq_q(out_freq_q), .block_cmd(block_cmd), .aux_cmd(aux_cmd),
      .load_pct(load_pct), .term_in(term_in), .meas_rpm(meas_rpm),
      .out_cur_pct(out_cur_pct));

   // Verdict and end of run
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results

   // Bounded wait for hready at a rising edge
   task automatic phase_end();
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         $display("Bus wait ran out t=%0t", $time);
         results();
      end
   endtask : phase_end

   // One single word transfer
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      phase_end();
      htrans <= 2'h0;
      hwdata <= wd;
      phase_end();
      rd = hrdata;
      #1;
   endtask : bus

   initial begin
      rows = '{
         '{1'b0, OFS_IN_FUNC0, 32'h0, 32'h1}, '{1'b0, 8'h18, 32'h0, 32'h1},
         '{1'b0, OFS_RELAY_ONE, 32'h0, 32'hE},
         '{1'b0, OFS_RELAY_TWO, 32'h0, 32'hE},
         '{1'b0, OFS_GAIN, 32'h0, 32'h3E8},
         '{1'b0, OFS_TH_ACTION, 32'h0, 32'h0},
         '{1'b0, OFS_COOLING, 32'h0, 32'h0},
         '{1'b0, OFS_ONE_MIN, 32'h0, 32'h96},
         '{1'b0, OFS_CONT, 32'h0, 32'h78}, '{1'b0, OFS_SS_EN, 32'h0, 32'h0},
         '{1'b1, OFS_ONE_MIN, 32'h77, 32'h96},
         '{1'b1, OFS_ONE_MIN, 32'hC9, 32'h96},
         '{1'b1, OFS_ONE_MIN, 32'hC8, 32'hC8},
         '{1'b1, OFS_ONE_MIN, 32'h78, 32'h78},
         '{1'b1, OFS_CONT, 32'h31, 32'h78}, '{1'b1, OFS_CONT, 32'h97, 32'h78},
         '{1'b1, OFS_CONT, 32'h32, 32'h32},
         '{1'b1, OFS_TH_ACTION, 32'h3, 32'h0},
         '{1'b1, OFS_TH_ACTION, 32'h2, 32'h2},
         '{1'b1, OFS_TH_ACTION, 32'h1, 32'h1},
         '{1'b1, OFS_IN_FUNC0, 32'h35, 32'h1},
         '{1'b1, OFS_IN_FUNC0, 32'h0, 32'h1},
         '{1'b1, OFS_RELAY_ONE, 32'h2D, 32'hE},
         '{1'b1, OFS_RELAY_ONE, 32'h0, 32'hE},
         '{1'b1, OFS_GAIN, 32'h9, 32'h3E8},
         '{1'b1, OFS_GAIN, 32'h7D0, 32'h7D0},
         '{1'b1, 8'h60, 32'h5, 32'h0}, '{1'b1, OFS_COOLING, 32'h1, 32'h1},
         '{1'b1, OFS_RELAY_TWO, 32'h5, 32'h5}};
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Settings: defaults, ranges and refusals
      foreach (rows[i]) begin
         if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0);
         `CHK(rd, rows[i].e)
         `CHK(hresp, 1'b0)
      end
      $display("Settings table done");
      // Run with input 2 as block request
      bus(1'b1, OFS_IN_FUNC0 + 8'h08, 32'h21);
      bus(1'b1, OFS_CMD_FREQ, 32'h40);
      bus(1'b1, OFS_SS_START, 32'h10);
      bus(1'b1, OFS_CTRL, 32'h1);
      `WAIT_UNTIL(out_freq_q === 16'h0040, 200)
      `CHK(stage_en_q, 1'b1)
      `CHK(relay_q, 2'b01)
      repeat (6) @(posedge ref_clk);
      #1;
      `CHK(disp_speed_q, 16'h0080)
      @(posedge ref_clk) aux_cmd <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      `CHK(stage_en_q, 1'b1)
      @(posedge ref_clk) aux_cmd <= 1'b0;
      $display("Run test done");
      // Block while at constant speed
      @(posedge ref_clk) block_cmd <= 1'b1;
      `WAIT_UNTIL(stage_en_q === 1'b0, 10)
      `CHK(out_freq_q, 16'h0000)
      `CHK(disp_block_q, 1'b1)
      `CHK(relay_q, 2'b01)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[2:0], 3'h2)
      @(posedge ref_clk) block_cmd <= 1'b0;
      `WAIT_UNTIL(stage_en_q === 1'b1, 10)
      `CHK(out_freq_q, 16'h0010)
      `CHK(disp_block_q, 1'b0)
      `WAIT_UNTIL(out_freq_q === 16'h0040, 100)
      bus(1'b0, OFS_FAULT_CNT, 32'h0);
      `CHK(rd, 32'h0)
      $display("Block test done");
      // Thermal trip with coasting action
      @(posedge ref_clk) load_pct <= 8'hC8;
      `WAIT_UNTIL(stage_en_q === 1'b0, 3000)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[7], 1'b1)
      bus(1'b0, OFS_FAULT_CNT, 32'h0);
      `CHK(rd, 32'h1)
      // Thermal trip with deceleration action
      @(posedge ref_clk) load_pct <= 8'h00;
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_TH_ACTION, 32'h2);
      bus(1'b1, OFS_SS_EN, 32'h1);
      repeat (200) @(posedge ref_clk);
      bus(1'b1, OFS_CTRL, 32'h1);
      @(posedge ref_clk);
      #1;
      `CHK(out_freq_q, 16'h0010)
      `WAIT_UNTIL(out_freq_q === 16'h0040, 200)
      @(posedge ref_clk) load_pct <= 8'hC8;
      `WAIT_UNTIL(out_freq_q !== 16'h0040, 3000)
      `CHK(stage_en_q, 1'b1)
      `WAIT_UNTIL(out_freq_q === 16'h0000, 200)
      $display("Thermal test done");
      // Reset after the deceleration trip, with run still on and the stage already off
      @(posedge ref_clk) rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(stage_en_q, 1'b0)
      `CHK(relay_q, 2'b00)
      @(posedge ref_clk) rst_n <= 1'b1;
      bus(1'b0, OFS_GAIN, 32'h0);
      `CHK(rd, 32'h3E8)
      $display("Reset test done");
      results();
   end
endmodule : obtc_drive_ctrl_bench
